// ===== rtl/opcode_decoder_consts.vh
// Register offsets, control bit positions and operation codes for the decoder
`ifndef OPCODE_DECODER_CONSTS_VH
`define OPCODE_DECODER_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define REG_BYTES      8'h00
`define REG_CTRL       8'h04
`define REG_OP         8'h08
`define REG_FIELDS     8'h0C
`define REG_IMM        8'h10
`define REG_DISP       8'h14
`define REG_STATUS     8'h18
`define CTRL_START_BIT 0
`define CTRL_CLR_BIT   1

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_NONE        6'h00
`define OP_COPY_RM     6'h01
`define OP_COPY_IMM    6'h02
`define OP_COPY_MEM2A  6'h03
`define OP_COPY_A2MEM  6'h04
`define OP_COPY_TOSEG  6'h05
`define OP_COPY_FROMSEG 6'h06
`define OP_SWAP        6'h07
`define OP_LOOKUP      6'h08
`define OP_LOAD_EO     6'h09
`define OP_LFP_DATA    6'h0A
`define OP_LFP_EXTRA   6'h0B
`define OP_FLAGS2AH    6'h0C
`define OP_AH2FLAGS    6'h0D
`define OP_SUB_ONE     6'h0E
`define OP_INVERT      6'h0F
`define OP_NEGATE      6'h10
`define OP_UPRODUCT    6'h11
`define OP_SPRODUCT    6'h12
`define OP_UQUOTIENT   6'h13
`define OP_SQUOTIENT   6'h14
`define OP_COMPARE_IMM 6'h15
`define OP_ASCII_SUB   6'h16
`define OP_DEC_SUB     6'h17
`define OP_ASCII_MUL   6'h18
`define OP_SIGN_EXT    6'h19
`define OP_ROT_L       6'h1A
`define OP_ROT_R       6'h1B
`define OP_ROT_LC      6'h1C
`define OP_ROT_RC      6'h1D
`define OP_SHIFT_L     6'h1E
`define OP_LSHIFT_R    6'h1F
`define OP_ASHIFT_R    6'h20
`define OP_CONJ        6'h21

`endif

// ===== rtl/opcode_decoder_data_arith.v
// Instruction decoder for copy and arithmetic/logic opcode groups, AHB-Lite slave
//
// Contract
// - 100010dw plus addressing byte is register/memory copy; d picks target.
// - 1011w reg is immediate-to-register copy, one or two immediate bytes.
// - Accumulator/memory copies carry two-byte direct address, low first, no addressing byte.
// - 10001110 copies register/memory into segment register from addressing byte.
// - 10001100 copies segment register into register/memory operand.
// - 1000011w with addressing byte swaps register and register/memory operand.
// - 11010111 is single-byte table lookup into accumulator low byte.
// - 10001101 loads computed effective offset into selected register.
// - 11000101 and 11000100 load far pointer with data or extra segment.
// - 10011111 flags to accumulator high; 10011110 the reverse.
// - 1111111w with field 001 subtracts one from operand.
// - 1111011w field selects invert, negate, products and quotients.
// - 100000sw field 111 is immediate compare; 16-bit immediate only when sw=01.
// - 00111111 and 00101111 are ASCII and decimal subtract adjustments.
// - ASCII adjust multiply is 11010100 then 00001010, both bytes consumed.
// - 10011000 sign-extends accumulator low byte into full accumulator.
// - 110100vw field selects rotates, shift left, logical and arithmetic right.
// - 001000dw with addressing byte is bitwise conjunction, direction by d.
// - Size bit one means word operation, zero means byte.
// - Mode 11 makes operand-select field name a register.
// - sw=11 sign-extends one immediate byte to 16 bits.
// - Register field maps to word or byte registers by size bit.
`timescale 1ns/10ps
`default_nettype none
`include "opcode_decoder_consts.vh"

module opcode_decoder_data_arith (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rstn,
    // AHB-Lite slave
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output wire        o_hreadyout,
    output wire        o_hresp,
    output reg  [31:0] o_hrdata,
    // Decoder result strobe
    output reg         o_decode_done
);

    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------
    // Address phase state carried into the data phase
    reg        wr_pend_ff;
    reg        rd_pend_ff;
    reg [7:0]  addr_ff;
    wire       take = i_hsel & i_hready & i_htrans[1];

    // Zero wait states; errors never produced
    // No wait states, so this slave's hreadyout stays high at all times
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // Address phase registered for the following data phase
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 8'h00;
        end else begin
            wr_pend_ff <= take & i_hwrite;
            rd_pend_ff <= take & ~i_hwrite;
            addr_ff    <= i_haddr[7:0];
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    // Map: 0x00 window, 0x04 control (bit 0 start, bit 1 clear valid)
    // Op word 0x08: [5:0] code, [8:6] length, [9] handled
    // Fields 0x0C: [0] wide, [1] dir, [2] addressing byte, [3] register operand,
    // Then [5:4] mode, [8:6] reg, [11:9] r/m, [13:12] segment, [14] count
    // Immediate 0x10, displacement or direct address 0x14, valid 0x18 bit 0
    // Only four bytes are visible; longer forms read zero past them
    reg [31:0] bytes_ff;       // Up to four instruction bytes, first in [7:0]
    reg        start_ff;       // One-cycle decode request
    reg        valid_ff;       // Sticky result valid
    // Decoded result, captured one cycle after the start write
    reg [5:0]  op_ff;
    reg        handled_ff;
    reg [2:0]  len_ff;
    reg        wide_ff;
    reg        dir_ff;
    reg        has_modrm_ff;
    reg        reg_is_rm_ff;
    reg [1:0]  mode_ff;
    reg [2:0]  regf_ff;
    reg [2:0]  rmf_ff;
    reg [1:0]  seg_ff;
    reg        count_cl_ff;
    reg [15:0] imm_ff;
    reg [15:0] disp_ff;

    // Write strobes come from the registered address phase
    wire wr_bytes = wr_pend_ff & (addr_ff == `REG_BYTES);
    wire wr_ctrl  = wr_pend_ff & (addr_ff == `REG_CTRL);

    // ----------------------------------------
    // Combinational decode of the byte window
    // ----------------------------------------
    // Opcode byte and addressing byte fields
    wire [7:0] b0 = bytes_ff[7:0];
    wire [7:0] b1 = bytes_ff[15:8];
    wire [1:0] md = b1[7:6];
    wire [2:0] rf = b1[5:3];
    wire [2:0] rm = b1[2:0];

    // Decode of the current window, ahead of the start strobe
    reg [5:0]  nxt_op;
    reg        nxt_handled;
    reg        nxt_modrm;
    reg        nxt_wide;
    reg        nxt_dir;
    reg [1:0]  imm_n;          // Immediate bytes after displacement
    reg        imm_sx;         // Sign-extend a single immediate byte
    reg        addr_direct;    // Two address bytes follow opcode
    reg [2:0]  nxt_len;
    reg [1:0]  disp_n;
    reg [2:0]  nxt_regf;
    reg [15:0] nxt_imm;
    reg [15:0] nxt_disp;
    reg [7:0]  ib0;
    reg [7:0]  ib1;

    // Opcode classification
    // Groups do not overlap, so the order of the tests is free
    // Segment forms with the top field bit set are left not handled
    // Each branch sets what differs from the defaults; OP_LOAD_EO and OP_ASCII_MUL also restate the default size bit
    always @* begin
        nxt_op      = `OP_NONE;
        nxt_handled = 1'b1;
        nxt_modrm   = 1'b0;
        nxt_wide    = b0[0];
        nxt_dir     = b0[1];
        imm_n       = 2'd0;
        imm_sx      = 1'b0;
        addr_direct = 1'b0;
        nxt_regf    = rf;
        if (b0[7:2] == 6'b100010) begin
            nxt_op    = `OP_COPY_RM;
            nxt_modrm = 1'b1;
        end else if (b0[7:4] == 4'b1011) begin
            nxt_op   = `OP_COPY_IMM;
            nxt_wide = b0[3];
            nxt_regf = b0[2:0];
            imm_n    = b0[3] ? 2'd2 : 2'd1;
        end else if (b0[7:1] == 7'b1010000) begin
            nxt_op      = `OP_COPY_MEM2A;
            addr_direct = 1'b1;
        end else if (b0[7:1] == 7'b1010001) begin
            nxt_op      = `OP_COPY_A2MEM;
            addr_direct = 1'b1;
        end else if (b0 == 8'b10001110 && !rf[2]) begin
            nxt_op    = `OP_COPY_TOSEG;
            nxt_modrm = 1'b1;
            nxt_wide  = 1'b1;
        end else if (b0 == 8'b10001100 && !rf[2]) begin
            nxt_op    = `OP_COPY_FROMSEG;
            nxt_modrm = 1'b1;
            nxt_wide  = 1'b1;
        end else if (b0[7:1] == 7'b1000011) begin
            nxt_op    = `OP_SWAP;
            nxt_modrm = 1'b1;
        end else if (b0 == 8'b11010111) begin
            nxt_op   = `OP_LOOKUP;
            nxt_wide = 1'b0;
        end else if (b0 == 8'b10001101) begin
            nxt_op    = `OP_LOAD_EO;
            nxt_modrm = 1'b1;
            nxt_wide  = 1'b1;
        end else if (b0 == 8'b11000101 || b0 == 8'b11000100) begin
            nxt_op    = b0[0] ? `OP_LFP_DATA : `OP_LFP_EXTRA;
            nxt_modrm = 1'b1;
            nxt_wide  = 1'b1;
        end else if (b0 == 8'b10011111 || b0 == 8'b10011110) begin
            nxt_op   = b0[0] ? `OP_FLAGS2AH : `OP_AH2FLAGS;
            nxt_wide = 1'b0;
        end else if (b0[7:1] == 7'b1111111 && rf == 3'b001) begin
            nxt_op    = `OP_SUB_ONE;
            nxt_modrm = 1'b1;
        end else if (b0[7:1] == 7'b1111011 && rf[2:1] != 2'b00) begin
            nxt_modrm = 1'b1;
            case (rf)
                3'b010:  nxt_op = `OP_INVERT;
                3'b011:  nxt_op = `OP_NEGATE;
                3'b100:  nxt_op = `OP_UPRODUCT;
                3'b101:  nxt_op = `OP_SPRODUCT;
                3'b110:  nxt_op = `OP_UQUOTIENT;
                default: nxt_op = `OP_SQUOTIENT;
            endcase
        end else if (b0[7:2] == 6'b100000 && rf == 3'b111) begin
            nxt_op    = `OP_COMPARE_IMM;
            nxt_modrm = 1'b1;
            imm_n     = (b0[1:0] == 2'b01) ? 2'd2 : 2'd1;
            imm_sx    = (b0[1:0] == 2'b11);
        end else if (b0 == 8'b00111111 || b0 == 8'b00101111) begin
            nxt_op   = b0[4] ? `OP_ASCII_SUB : `OP_DEC_SUB;
            nxt_wide = 1'b0;
        end else if (b0 == 8'b11010100 && b1 == 8'b00001010) begin
            nxt_op   = `OP_ASCII_MUL;
            nxt_wide = 1'b0;
        end else if (b0 == 8'b10011000) begin
            nxt_op   = `OP_SIGN_EXT;
            nxt_wide = 1'b1;
        end else if (b0[7:2] == 6'b110100 && rf != 3'b110) begin
            nxt_modrm = 1'b1;
            case (rf)
                3'b000:  nxt_op = `OP_ROT_L;
                3'b001:  nxt_op = `OP_ROT_R;
                3'b010:  nxt_op = `OP_ROT_LC;
                3'b011:  nxt_op = `OP_ROT_RC;
                3'b100:  nxt_op = `OP_SHIFT_L;
                3'b101:  nxt_op = `OP_LSHIFT_R;
                default: nxt_op = `OP_ASHIFT_R;
            endcase
        end else if (b0[7:2] == 6'b001000) begin
            nxt_op    = `OP_CONJ;
            nxt_modrm = 1'b1;
        end else begin
            nxt_handled = 1'b0;
        end
    end

    // Displacement size, immediates and total length
    // Mode 00 with r/m 110 is a bare 16-bit address, not a base register
    always @* begin
        disp_n = 2'd0;
        if (nxt_modrm) begin
            case (md)
                2'b00:   disp_n = (rm == 3'b110) ? 2'd2 : 2'd0;
                2'b01:   disp_n = 2'd1;
                2'b10:   disp_n = 2'd2;
                default: disp_n = 2'd0;
            endcase
        end
        // Displacement bytes follow the addressing byte
        nxt_disp = 16'h0000;
        // A short displacement is sign-extended from its own top bit
        if (disp_n == 2'd1) begin
            nxt_disp = {{8{bytes_ff[23]}}, bytes_ff[23:16]};
        end else if (disp_n == 2'd2) begin
            nxt_disp = bytes_ff[31:16];
        end
        // Direct address of accumulator copies, low byte first
        if (addr_direct) begin
            nxt_disp = {bytes_ff[23:16], b1};
        end
        // Immediate bytes sit after opcode, addressing byte and displacement
        ib0 = 8'h00;
        ib1 = 8'h00;
        case ({nxt_modrm, disp_n})
            3'b100:  begin ib0 = bytes_ff[23:16]; ib1 = bytes_ff[31:24]; end
            3'b101:  begin ib0 = bytes_ff[31:24]; ib1 = 8'h00; end
            3'b000:  begin ib0 = b1; ib1 = bytes_ff[23:16]; end
            default: begin ib0 = 8'h00; ib1 = 8'h00; end
        endcase
        if (imm_n == 2'd2) begin
            nxt_imm = {ib1, ib0};
        end else if (imm_n == 2'd1) begin
            nxt_imm = imm_sx ? {{8{ib0[7]}}, ib0} : {8'h00, ib0};
        end else begin
            nxt_imm = 16'h0000;
        end
        // Opcode + addressing + displacement + immediate
        // Longest form is six bytes, inside the three-bit length
        nxt_len = 3'd1 + {2'b00, nxt_modrm} + {1'b0, disp_n} + {1'b0, imm_n}
                  + (addr_direct ? 3'd2 : 3'd0)
                  + ((nxt_op == `OP_ASCII_MUL) ? 3'd1 : 3'd0);
        // Unknown bytes advance the fetch side by one so it can resync
        if (!nxt_handled) begin
            nxt_len = 3'd1;
        end
    end

    // ----------------------------------------
    // Result registers and control
    // ----------------------------------------
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bytes_ff      <= 32'h0000_0000;
            start_ff      <= 1'b0;
            valid_ff      <= 1'b0;
            op_ff         <= `OP_NONE;
            handled_ff    <= 1'b0;
            len_ff        <= 3'd0;
            wide_ff       <= 1'b0;
            dir_ff        <= 1'b0;
            has_modrm_ff  <= 1'b0;
            reg_is_rm_ff  <= 1'b0;
            mode_ff       <= 2'b00;
            regf_ff       <= 3'b000;
            rmf_ff        <= 3'b000;
            seg_ff        <= 2'b00;
            count_cl_ff   <= 1'b0;
            imm_ff        <= 16'h0000;
            disp_ff       <= 16'h0000;
            o_decode_done <= 1'b0;
        end else begin
            // Window is written whole, first byte in the low lane
            if (wr_bytes) begin
                bytes_ff <= i_hwdata;
            end
            // Start is registered so decode sees the window written before it
            start_ff      <= wr_ctrl & i_hwdata[`CTRL_START_BIT];
            o_decode_done <= start_ff;
            // Completion wins over a same-cycle software clear
            if (start_ff) begin
                valid_ff <= 1'b1;
            end else if (wr_ctrl & i_hwdata[`CTRL_CLR_BIT]) begin
                valid_ff <= 1'b0;
            end
            // Results move only on a start, so reads between decodes are steady
            if (start_ff) begin
                op_ff        <= nxt_op;
                handled_ff   <= nxt_handled;
                len_ff       <= nxt_len;
                wide_ff      <= nxt_wide;
                dir_ff       <= nxt_dir;
                has_modrm_ff <= nxt_modrm;
                reg_is_rm_ff <= nxt_modrm & (md == 2'b11);
                mode_ff      <= md;
                regf_ff      <= nxt_regf;
                rmf_ff       <= rm;
                seg_ff       <= rf[1:0];
                count_cl_ff  <= b0[1];
                imm_ff       <= nxt_imm;
                disp_ff      <= nxt_disp;
            end
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Register read mux; unmapped offsets read zero
    // Loaded at the address phase, so it stands through the data phase
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_hrdata <= 32'h0000_0000;
        end else if (take & ~i_hwrite) begin
            case (i_haddr[7:0])
                `REG_BYTES:  o_hrdata <= bytes_ff;
                `REG_OP:     o_hrdata <= {22'h00_0000, handled_ff, len_ff, op_ff};
                `REG_FIELDS: o_hrdata <= {17'h0_0000, count_cl_ff, seg_ff, rmf_ff,
                                          regf_ff, mode_ff, reg_is_rm_ff,
                                          has_modrm_ff, dir_ff, wide_ff};
                `REG_IMM:    o_hrdata <= {16'h0000, imm_ff};
                `REG_DISP:   o_hrdata <= {16'h0000, disp_ff};
                `REG_STATUS: o_hrdata <= {31'h00000000, valid_ff};
                default:     o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Read-pending flag kept for bus phase tracking
    // Transfer size is ignored; every register is one whole word
    wire unused_ok = rd_pend_ff | (|i_hsize);

endmodule
`default_nettype wire

// ===== tb/fetch_queue_model.sv
// Fetch-side model: a stream of test instructions, advanced by accepted length
`timescale 1ns/10ps
`default_nettype none

module fetch_queue_model (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Advance request from the bench
    input  wire logic        i_adv,
    input  wire logic [2:0]  i_len,
    // Next four bytes, oldest byte in the low lane
    output logic      [31:0] o_bytes
);
    logic [7:0] mem [0:87];
    logic [6:0] ptr_ff;

    // Byte stream, little-endian immediates and addresses; zero pad at the tail
    initial begin
        mem = '{8'h89, 8'hD8, 8'hB8, 8'h34, 8'h12, 8'hB0, 8'h7F, 8'hA1, 8'h78, 8'h56,
                8'hA3, 8'h78, 8'h56, 8'h8E, 8'hD8, 8'h8C, 8'hC0, 8'h87, 8'hCA, 8'h8D,
                8'h06, 8'h34, 8'h12, 8'hD7, 8'hC5, 8'h47, 8'hF0, 8'hC4, 8'h87, 8'h00,
                8'h01, 8'h9F, 8'h9E, 8'h98, 8'h3F, 8'h2F, 8'hD4, 8'h0A, 8'hFE, 8'hC8,
                8'hF7, 8'hD0, 8'hF7, 8'hD8, 8'hF7, 8'hE0, 8'hF7, 8'hE8, 8'hF7, 8'hF0,
                8'hF7, 8'hF8, 8'h81, 8'hF8, 8'h34, 8'h12, 8'h83, 8'hF8, 8'h80, 8'h80,
                8'hF8, 8'h05, 8'hD1, 8'hC0, 8'hD1, 8'hC8, 8'hD1, 8'hD0, 8'hD1, 8'hD8,
                8'hD1, 8'hE0, 8'hD3, 8'hE8, 8'hD2, 8'hF8, 8'h21, 8'hC8, 8'h22, 8'hC8,
                8'h0F, 8'h8E, 8'hE0, 8'hF4, 8'h00, 8'h00, 8'h00, 8'h00};
    end

    // Pointer moves only by the expected length, so a wrong decoded length does not derail later cases
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ptr_ff <= 7'd0;
        end else if (i_adv) begin
            ptr_ff <= ptr_ff + 7'(i_len);
        end
    end
    assign o_bytes = {mem[ptr_ff + 7'd3], mem[ptr_ff + 7'd2], mem[ptr_ff + 7'd1], mem[ptr_ff]};
endmodule
`default_nettype wire

// ===== tb/opcode_decoder_data_arith_asserts.sv
// Bus and decode-strobe properties of the opcode decoder
`timescale 1ns/10ps
`default_nettype none
`include "opcode_decoder_consts.vh"

module opcode_decoder_data_arith_chk (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rstn,
    // Bus side
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_decode_done
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic       take;
    logic       start;
    logic       rd_op;
    logic       ap_ff;
    logic       apw_ff;
    logic [7:0] apa_ff;
    logic       seen_ff;

    // ----------------------------------------
    // Address phase tracking
    // ----------------------------------------
    // Write data arrives one cycle after its address, so qualifiers are kept
    assign take  = i_hsel & i_hready & i_htrans[1];
    assign start = ap_ff & apw_ff & (apa_ff == `REG_CTRL) & i_hwdata[0];
    assign rd_op = take & !i_hwrite & (i_haddr[7:0] == `REG_OP) & seen_ff;
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ap_ff   <= 1'b0;
            apw_ff  <= 1'b0;
            apa_ff  <= 8'h00;
            seen_ff <= 1'b0;
        end else begin
            ap_ff   <= take;
            apw_ff  <= i_hwrite;
            apa_ff  <= i_haddr[7:0];
            seen_ff <= seen_ff | o_decode_done;
        end
    end

    chk_ready_const: assert property (o_hreadyout)
        else $error("hreadyout dropped low");
    chk_resp_okay: assert property (!o_hresp)
        else $error("error response seen");
    chk_done_latency: assert property (start |-> ##[2:3] o_decode_done)
        else $error("decode strobe late or missing");
    chk_done_cause: assert property ($rose(o_decode_done) |-> $past(start, 2) || $past(start, 3))
        else $error("decode strobe without start");
    chk_done_pulse: assert property (o_decode_done |=> !o_decode_done)
        else $error("decode strobe longer than one cycle");
    chk_rdata_holds: assert property ((!take || i_hwrite) |=> $stable(o_hrdata))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (take && !i_hwrite && i_haddr > 32'h0000_0018
        |=> o_hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_length_range: assert property (rd_op |=> o_hrdata[8:6] inside {[3'd1:3'd6]})
        else $error("reported length out of range");
    chk_unhandled_form: assert property (rd_op |=> (o_hrdata[9] == (o_hrdata[5:0] != 6'h00))
        && (o_hrdata[9] || o_hrdata[8:6] == 3'd1))
        else $error("unhandled result malformed");
    cov_start: cover property (start);
    cov_done: cover property (o_decode_done);
    cov_read_op: cover property (rd_op);
endmodule

bind opcode_decoder_data_arith opcode_decoder_data_arith_chk u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
    .o_decode_done(o_decode_done));
`default_nettype wire

// ===== tb/opcode_decoder_data_arith_test.sv
// Self-checking bench for the copy and arithmetic opcode decoder
`timescale 1ns/10ps
`default_nettype none
`include "opcode_decoder_consts.vh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module opcode_decoder_data_arith_test;
    logic        i_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        adv = 1'b0;
    logic [2:0]  alen = 3'd0;
    wire         hready;
    wire  [31:0] hrdata;
    wire         done;
    wire  [31:0] win;
    int          bad_count = 0;
    int          checks = 0;

    // ----------------------------------------
    // Clock, design and fetch side
    // ----------------------------------------
    always #2 i_clk = ~i_clk;
    opcode_decoder_data_arith uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(),
        .o_hrdata(hrdata), .o_decode_done(done));
    fetch_queue_model fq (.i_clk(i_clk), .i_rstn(i_rstn), .i_adv(adv), .i_len(alen),
        .o_bytes(win));

    // ----------------------------------------
    // Bus and decode helpers
    // ----------------------------------------
    // Single transfer; waits on hready instead of assuming zero wait states
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        xfer(a, 1'b0, 32'h0000_0000, v);
        `CHK(v & m, e)
    endtask
    // Leading edge lets the fetch pointer settle before its bytes are sampled
    task automatic dec(input logic [5:0] op, input logic [2:0] len);
        logic [31:0] v;
        @(posedge i_clk);
        xfer(`REG_BYTES, 1'b1, win, v);
        xfer(`REG_CTRL, 1'b1, 32'h0000_0001, v);
        do @(posedge i_clk); while (done !== 1'b1);
        xfer(`REG_OP, 1'b0, 32'h0000_0000, v);
        `CHK(v[9:0], {op != `OP_NONE, len, op})
        adv  <= 1'b1;
        alen <= len;
        @(posedge i_clk);
        adv  <= 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regs;
        logic [31:0] v;
        rdchk(`REG_OP, 32'h0000_03FF, 32'h0000_0000);
        rdchk(`REG_STATUS, 32'h0000_0001, 32'h0000_0000);
        xfer(`REG_BYTES, 1'b1, 32'hA5A5_5A5A, v);
        rdchk(`REG_BYTES, 32'hFFFF_FFFF, 32'hA5A5_5A5A);
        xfer(8'h40, 1'b1, 32'hFFFF_FFFF, v);
        rdchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
    endtask
    task automatic test_copy;
        dec(`OP_COPY_RM, 3'd2);
        rdchk(`REG_FIELDS, 32'h0000_0FFF, 32'h0000_00FD);
        dec(`OP_COPY_IMM, 3'd3);
        rdchk(`REG_IMM, 32'h0000_FFFF, 32'h0000_1234);
        dec(`OP_COPY_IMM, 3'd2);
        dec(`OP_COPY_MEM2A, 3'd3);
        rdchk(`REG_DISP, 32'h0000_FFFF, 32'h0000_5678);
        dec(`OP_COPY_A2MEM, 3'd3);
        dec(`OP_COPY_TOSEG, 3'd2);
        rdchk(`REG_FIELDS, 32'h0000_3000, 32'h0000_3000);
        dec(`OP_COPY_FROMSEG, 3'd2);
        dec(`OP_SWAP, 3'd2);
        dec(`OP_LOAD_EO, 3'd4);
        rdchk(`REG_DISP, 32'h0000_FFFF, 32'h0000_1234);
    endtask
    task automatic test_misc;
        dec(`OP_LOOKUP, 3'd1);
        dec(`OP_LFP_DATA, 3'd3);
        rdchk(`REG_DISP, 32'h0000_FFFF, 32'h0000_FFF0);
        dec(`OP_LFP_EXTRA, 3'd4);
        dec(`OP_FLAGS2AH, 3'd1);
        dec(`OP_AH2FLAGS, 3'd1);
        dec(`OP_SIGN_EXT, 3'd1);
        dec(`OP_ASCII_SUB, 3'd1);
        dec(`OP_DEC_SUB, 3'd1);
        dec(`OP_ASCII_MUL, 3'd2);
    endtask
    // Invert through signed quotient are consecutive codes, so a loop covers all six
    task automatic test_arith;
        dec(`OP_SUB_ONE, 3'd2);
        for (int k = 0; k < 6; k++) begin
            dec(6'(`OP_INVERT + k), 3'd2);
        end
        dec(`OP_COMPARE_IMM, 3'd4);
        rdchk(`REG_IMM, 32'h0000_FFFF, 32'h0000_1234);
        dec(`OP_COMPARE_IMM, 3'd3);
        rdchk(`REG_IMM, 32'h0000_FFFF, 32'h0000_FF80);
        dec(`OP_COMPARE_IMM, 3'd3);
    endtask
    task automatic test_shift;
        for (int k = 0; k < 6; k++) begin
            dec(6'(`OP_ROT_L + k), 3'd2);
        end
        rdchk(`REG_FIELDS, 32'h0000_4001, 32'h0000_4001);
        dec(`OP_ASHIFT_R, 3'd2);
        rdchk(`REG_FIELDS, 32'h0000_4001, 32'h0000_4000);
        dec(`OP_CONJ, 3'd2);
        dec(`OP_CONJ, 3'd2);
        rdchk(`REG_FIELDS, 32'h0000_0FFF, 32'h0000_007E);
        dec(`OP_NONE, 3'd1);
        dec(`OP_NONE, 3'd1);
        dec(`OP_NONE, 3'd1);
        dec(`OP_NONE, 3'd1);
    endtask
    // Clear alone drops valid; start with clear must still leave valid set
    task automatic test_status;
        logic [31:0] v;
        rdchk(`REG_STATUS, 32'h0000_0001, 32'h0000_0001);
        xfer(`REG_CTRL, 1'b1, 32'h0000_0002, v);
        rdchk(`REG_STATUS, 32'h0000_0001, 32'h0000_0000);
        xfer(`REG_CTRL, 1'b1, 32'h0000_0003, v);
        do @(posedge i_clk); while (done !== 1'b1);
        rdchk(`REG_STATUS, 32'h0000_0001, 32'h0000_0001);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence after four reset cycles
    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        test_regs();
        test_copy();
        test_misc();
        test_arith();
        test_shift();
        test_status();
        end_of_test();
    end
    // Whole run needs under a thousand cycles; this cuts a hang short
    initial begin
        #20000;
        bad_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
